// File: scr_bank.sv
// serial-port configuration and identification register bank
`timescale 1ns/1ps
`include "scr_consts.svh"
module scr_bank
	import scr_pkg::*;
#(
	parameter logic [7:0] CLASS_CODE = 8'h11, // arbitrary value
	parameter logic [15:0] PART_ID   = 16'h2233, // arbitrary value
	parameter logic [3:0] GRADE_CODE = 4'h5, // arbitrary value
	parameter logic [7:0] REV_CODE   = 8'h07, // arbitrary value
	parameter logic [15:0] MAKER_ID  = 16'h6789 // arbitrary value
)(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RSTN,
	// serial port pins
	input  wire logic       SCLK,
	input  wire logic       CHIP_SELECT_N,
	input  wire logic       SDIO_IN,
	output logic            SDIO_OUT,
	output logic            SDIO_OE_N,
	// device pins and events
	input  wire logic       POWERDOWN_STANDBY_PIN,
	input  wire logic       SYSREF_CAPTURE,
	input  wire logic [3:0] DIVIDER_PHASE,
	input  wire logic       FAST_DETECT_FLAG,
	input  wire logic       FRAME_CLOCK,
	input  wire logic       XFER_DONE,
	// controls to the device
	output logic [1:0]      POWER_STATE,
	output logic            DATAPATH_RESET,
	output logic            XFER_REQUEST,
	output logic            FAST_DETECT_AUX_PIN,
	output logic            AUX_PIN_TWO_NCO_SELECT,
	output logic            DIVIDER_REALIGN,
	output logic [3:0]      DIVIDER_OFFSET,
	output logic [3:0]      DIVIDER_PHASE_OFFSET_PROG
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		scr_phase_type phase;
		logic [3:0]    cnt;
		logic [23:0]   sh;
		logic          rd;
		logic [14:0]   addr;
		logic [7:0]    rdata;
		logic          lsb_first;
		logic          ascend;
		logic [1:0]    pmode;
		logic [7:0]    scratch;
		logic          xfer;
		logic          gate;
		logic [7:0]    pin_pri;
		logic [3:0]    pin_sec;
		logic          auto_ph;
		logic [1:0]    neg_win;
		logic [1:0]    pos_win;
		logic [3:0]    ph_stat;
		logic [3:0]    soft_cnt;
		logic [3:0]    dp_cnt;
		logic          sdo;
		logic          oe_n;
		logic [1:0]    pstate;
		logic          fd_out;
		logic          nco_sel;
		logic          realign;
		logic [3:0]    offset;
		logic          dp_rst;
	} scr_state_type;
	scr_state_type r;
	scr_state_type next_r;
	logic sclk_s;
	logic cs_n_s;
	logic sdi_s;
	logic pin_s;
	logic sclk_rise;
	logic sclk_fall;
	logic sclk_low;
	logic [7:0] rd_byte;
	logic [7:0] wbyte;
	logic       in_bit;
	// ****************************************
	// pin synchronisers
	// ****************************************
	scr_sync u_sclk (.clk(CLK), .rstn(RSTN), .pin(SCLK), .level(sclk_s));
	scr_sync u_csn (.clk(CLK), .rstn(RSTN), .pin(CHIP_SELECT_N),
		.level(cs_n_s));
	scr_sync u_sdi (.clk(CLK), .rstn(RSTN), .pin(SDIO_IN), .level(sdi_s));
	scr_sync u_pin (.clk(CLK), .rstn(RSTN), .pin(POWERDOWN_STANDBY_PIN),
		.level(pin_s));
	scr_edge u_rise (.clk(CLK), .rstn(RSTN), .level(sclk_s),
		.rise(sclk_rise));
	scr_edge u_fall (.clk(CLK), .rstn(RSTN), .level(sclk_low),
		.rise(sclk_fall));
	assign sclk_low = ~sclk_s;
	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rd_byte = 8'h00;
		unique case (r.addr)
			`SCR_A_CFG_PRI:   rd_byte = {1'b0, r.lsb_first, r.ascend, 2'h0,
				r.ascend, r.lsb_first, 1'b0};
			`SCR_A_PWR:       rd_byte = {6'h0, r.pmode};
			`SCR_A_CLASS:     rd_byte = CLASS_CODE;
			`SCR_A_PID_LO:    rd_byte = PART_ID[7:0];
			`SCR_A_PID_HI:    rd_byte = PART_ID[15:8];
			`SCR_A_GRADE:     rd_byte = {GRADE_CODE, 4'h0};
			`SCR_A_SCRATCH:   rd_byte = r.scratch;
			`SCR_A_REV:       rd_byte = REV_CODE;
			`SCR_A_MAKER_LO:  rd_byte = MAKER_ID[7:0];
			`SCR_A_MAKER_HI:  rd_byte = MAKER_ID[15:8];
			`SCR_A_XFER:      rd_byte = {7'h0, r.xfer};
			`SCR_A_PIN_GATE:  rd_byte = {r.gate, 7'h0};
			`SCR_A_PIN_PRI:   rd_byte = r.pin_pri;
			`SCR_A_PIN_SEC:   rd_byte = {r.pin_sec, 4'h0};
			`SCR_A_DIV_ALIGN: rd_byte = {r.auto_ph, 3'h0, r.neg_win, r.pos_win};
			`SCR_A_DIV_STAT:  rd_byte = {4'h0, r.ph_stat};
			default:          rd_byte = 8'h00;
		endcase
	end
	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_r = r;
		in_bit = sdi_s;
		wbyte = r.lsb_first ? {in_bit, r.sh[7:1]} : {r.sh[6:0], in_bit};
		if (r.soft_cnt != 4'h0) begin
			next_r.soft_cnt = r.soft_cnt - 4'h1;
		end
		if (r.dp_cnt != 4'h0) begin
			next_r.dp_cnt = r.dp_cnt - 4'h1;
		end
		// transfer done clears first so a new write in the same cycle wins
		if (r.xfer && XFER_DONE) begin
			next_r.xfer = 1'b0;
		end
		// serial framing
		if (cs_n_s) begin
			next_r.phase = SCR_IDLE;
			next_r.cnt = 4'h0;
			next_r.oe_n = 1'b1;
		end else if (sclk_rise) begin
			next_r.sh = {r.sh[22:0], in_bit};
			next_r.cnt = r.cnt + 4'h1;
			unique case (r.phase)
				SCR_IDLE, SCR_INSTR: begin
					next_r.phase = SCR_INSTR;
					if (r.cnt == 4'hf) begin
						next_r.rd = r.sh[14];
						next_r.addr = {r.sh[13:0], in_bit};
						next_r.phase = SCR_DATA;
						next_r.cnt = 4'h0;
					end
				end
				SCR_DATA: begin
					if (r.lsb_first) begin
						next_r.sh[7:0] = wbyte;
					end
					if (r.cnt == 4'h7) begin
						next_r.cnt = 4'h0;
						next_r.addr = r.ascend ? r.addr + 15'h1 : r.addr - 15'h1;
						if (!r.rd) begin
							unique case (r.addr)
								`SCR_A_CFG_PRI: begin
									if (wbyte[7] | wbyte[0]) begin
										next_r.soft_cnt = `SCR_SOFT_RST_CYC;
									end
									next_r.lsb_first = wbyte[1] | wbyte[6];
									next_r.ascend = wbyte[2] | wbyte[5];
								end
								`SCR_A_CFG_SEC: begin
									if (wbyte[1]) begin
										next_r.dp_cnt = `SCR_SOFT_RST_CYC;
									end
								end
								`SCR_A_PWR:       next_r.pmode = wbyte[1:0];
								`SCR_A_SCRATCH:   next_r.scratch = wbyte;
								`SCR_A_XFER:      next_r.xfer = next_r.xfer | wbyte[0];
								`SCR_A_PIN_GATE:  next_r.gate = wbyte[7];
								`SCR_A_PIN_PRI:   next_r.pin_pri = wbyte;
								`SCR_A_PIN_SEC:   next_r.pin_sec = wbyte[7:4];
								`SCR_A_DIV_ALIGN: begin
									next_r.auto_ph = wbyte[7];
									next_r.neg_win = wbyte[3:2];
									next_r.pos_win = wbyte[1:0];
								end
								default: next_r.scratch = r.scratch;
							endcase
						end
					end
				end
				default: next_r.phase = SCR_IDLE;
			endcase
		end else if (sclk_fall && r.phase == SCR_DATA && r.rd) begin
			// read byte is latched at its first bit then shifted out
			if (r.cnt == 4'h0) begin
				next_r.rdata = rd_byte;
			end
			next_r.oe_n = 1'b0;
			next_r.sdo = r.lsb_first ? ((r.cnt == 4'h0) ? rd_byte[0] :
				r.rdata[r.cnt[2:0]]) : ((r.cnt == 4'h0) ? rd_byte[7] :
				r.rdata[3'h7 - r.cnt[2:0]]);
		end
		// pin override of the power mode
		next_r.pstate = r.pmode;
		if (!r.gate && pin_s) begin
			if (r.pin_pri[7:6] == `SCR_PINF_DOWN) begin
				next_r.pstate = `SCR_PWR_DOWN;
			end else if (r.pin_pri[7:6] == `SCR_PINF_STBY) begin
				next_r.pstate = `SCR_PWR_STANDBY;
			end
		end
		// aux pins
		unique case (r.pin_pri[2:0])
			`SCR_AUX_FD:    next_r.fd_out = FAST_DETECT_FLAG;
			`SCR_AUX_FRAME: next_r.fd_out = FRAME_CLOCK;
			default:        next_r.fd_out = 1'b0;
		endcase
		next_r.nco_sel = (r.pin_pri[5:3] == `SCR_AUX_SECOND) &&
			(r.pin_sec == `SCR_SEC_NCO);
		// divider phase alignment
		next_r.realign = 1'b0;
		if (r.auto_ph && SYSREF_CAPTURE) begin
			next_r.realign = 1'b1;
			next_r.ph_stat = DIVIDER_PHASE;
			next_r.offset = DIVIDER_PHASE + DIVIDER_PHASE_OFFSET_PROG;
		end
		// soft reset restores defaults on the last count
		if (r.soft_cnt == 4'h1) begin
			next_r = '0;
			next_r.pin_pri = `SCR_RST_PIN_PRI;
			next_r.oe_n = 1'b1;
			next_r.phase = SCR_IDLE;
		end
		next_r.dp_rst = (next_r.dp_cnt != 4'h0) ||
			(next_r.pstate == `SCR_PWR_DOWN);
	end
	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			r <= '0;
			r.pin_pri <= `SCR_RST_PIN_PRI;
			r.oe_n <= 1'b1;
			r.phase <= SCR_IDLE;
		end else begin
			r <= next_r;
		end
	end
	assign DIVIDER_PHASE_OFFSET_PROG = 4'h0;
	assign SDIO_OUT = r.sdo;
	assign SDIO_OE_N = r.oe_n;
	assign POWER_STATE = r.pstate;
	assign DATAPATH_RESET = r.dp_rst;
	assign XFER_REQUEST = r.xfer;
	assign FAST_DETECT_AUX_PIN = r.fd_out;
	assign AUX_PIN_TWO_NCO_SELECT = r.nco_sel;
	assign DIVIDER_REALIGN = r.realign;
	assign DIVIDER_OFFSET = r.offset;
	// ****************************************
	// checks
	// ****************************************
	a_xfer_hold: assert property (@(posedge CLK) disable iff (!RSTN)
		r.xfer && !XFER_DONE |=> r.xfer)
		else $error("transfer bit cleared early");
	a_pin_down: assert property (@(posedge CLK) disable iff (!RSTN)
		!r.gate && pin_s && r.pin_pri[7:6] == 2'h0 |=> POWER_STATE == 2'h3)
		else $error("pin did not force power-down");
	a_gate_ignore: assert property (@(posedge CLK) disable iff (!RSTN)
		r.gate |=> POWER_STATE == $past(r.pmode))
		else $error("gated pin changed power state");
	a_realign_cap: assert property (@(posedge CLK) disable iff (!RSTN)
		r.auto_ph && SYSREF_CAPTURE |=> DIVIDER_REALIGN &&
		r.ph_stat == $past(DIVIDER_PHASE))
		else $error("phase not captured");
	a_no_realign: assert property (@(posedge CLK) disable iff (!RSTN)
		!r.auto_ph |=> !DIVIDER_REALIGN)
		else $error("realign while disabled");
	a_soft_clear: assert property (@(posedge CLK) disable iff (!RSTN)
		r.soft_cnt == 4'h1 |=> r.scratch == 8'h00 && !r.lsb_first)
		else $error("soft reset left state");
	a_dp_pulse: assert property (@(posedge CLK) disable iff (!RSTN)
		$rose(r.dp_cnt != 4'h0) |-> (r.dp_cnt != 4'h0) [*8] ##1
		r.dp_cnt == 4'h0)
		else $error("datapath reset length wrong");
	a_fd_off: assert property (@(posedge CLK) disable iff (!RSTN)
		r.pin_pri[2:0] == 3'h7 |=> !FAST_DETECT_AUX_PIN)
		else $error("disabled aux pin driven");
	a_nco_sel: assert property (@(posedge CLK) disable iff (!RSTN)
		r.pin_pri[5:3] != 3'h6 |=> !AUX_PIN_TWO_NCO_SELECT)
		else $error("secondary function used wrongly");
	c_read: cover property (@(posedge CLK) $fell(SDIO_OE_N));
	c_soft: cover property (@(posedge CLK) r.soft_cnt == 4'h1);
	c_xfer: cover property (@(posedge CLK) r.xfer ##1 !r.xfer);
	c_stby: cover property (@(posedge CLK) POWER_STATE == 2'h2);
endmodule // scr_bank

// File: scr_bank_test.sv
// self-checking testbench for the serial register bank
`timescale 1ns/1ps
`include "scr_consts.svh"
module scr_bank_test
	import scr_pkg::*;
;
	localparam logic [7:0]  CLS = 8'h2c; // arbitrary value
	localparam logic [15:0] PID = 16'h4d1e; // arbitrary value
	localparam logic [3:0]  GRD = 4'h9; // arbitrary value
	localparam logic [7:0]  REV = 8'h3b; // arbitrary value
	localparam logic [15:0] MKR = 16'h7a52; // arbitrary value
	logic        clk, rstn, sclk, cs_n, sdio_in, sdio_out, sdio_oe_n;
	logic        pd_pin, sysref, fd_flag, frame_clk, xfer_done;
	logic        dp_reset, xfer_req, fd_pin, nco_sel, realign, lsb;
	logic [3:0]  phase, div_offset, div_prog;
	logic [1:0]  power_state;
	logic [15:0] q;
	logic [7:0]  b;
	int          miscompares, n_checks, dp_cnt, rl_cnt;
	// ****************
	// harness
	// ****************
	scr_bank #(.CLASS_CODE(CLS), .PART_ID(PID), .GRADE_CODE(GRD),
		.REV_CODE(REV), .MAKER_ID(MKR)) uut (.CLK(clk), .RSTN(rstn),
		.SCLK(sclk), .CHIP_SELECT_N(cs_n), .SDIO_IN(sdio_in),
		.SDIO_OUT(sdio_out), .SDIO_OE_N(sdio_oe_n),
		.POWERDOWN_STANDBY_PIN(pd_pin), .SYSREF_CAPTURE(sysref),
		.DIVIDER_PHASE(phase), .FAST_DETECT_FLAG(fd_flag),
		.FRAME_CLOCK(frame_clk), .XFER_DONE(xfer_done),
		.POWER_STATE(power_state), .DATAPATH_RESET(dp_reset),
		.XFER_REQUEST(xfer_req), .FAST_DETECT_AUX_PIN(fd_pin),
		.AUX_PIN_TWO_NCO_SELECT(nco_sel), .DIVIDER_REALIGN(realign),
		.DIVIDER_OFFSET(div_offset), .DIVIDER_PHASE_OFFSET_PROG(div_prog));
	scr_host host (.CLK(clk), .SCLK(sclk), .CHIP_SELECT_N(cs_n),
		.SDIO_IN(sdio_in), .SDIO_OUT(sdio_out), .SDIO_OE_N(sdio_oe_n));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) begin
		if (dp_reset === 1'b1) dp_cnt++;
		if (realign === 1'b1) rl_cnt++;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask
	// only mapped addresses, reserved bits written as zero
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, 1, {d, 8'h00}, lsb, q);
	endtask
	task automatic rdc(input logic [14:0] a, input logic [7:0] e,
		input string what);
		host.xfer(1'b1, a, 1, 16'h0000, lsb, q);
		check(q[15:8], e, what);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_defaults;
		rdc(`SCR_A_CFG_PRI, 8'h00, "cfg");
		rdc(`SCR_A_PWR, 8'h00, "power");
		rdc(`SCR_A_PIN_PRI, `SCR_RST_PIN_PRI, "pin pri");
		rdc(`SCR_A_DIV_ALIGN, 8'h00, "align");
		check(power_state, `SCR_PWR_NORMAL, "state");
		$display("done defaults");
	endtask
	task automatic t_ident;
		rdc(`SCR_A_CLASS, CLS, "class");
		rdc(`SCR_A_PID_LO, PID[7:0], "pid lo");
		rdc(`SCR_A_PID_HI, PID[15:8], "pid hi");
		host.xfer(1'b1, `SCR_A_GRADE, 1, 16'h0000, 1'b0, q);
		check(q[15:12], GRD, "grade");
		rdc(`SCR_A_REV, REV, "rev");
		rdc(`SCR_A_MAKER_LO, MKR[7:0], "maker lo");
		rdc(`SCR_A_MAKER_HI, MKR[15:8], "maker hi");
		wr(`SCR_A_CLASS, 8'hff);
		rdc(`SCR_A_CLASS, CLS, "ro write");
		rdc(15'h0013, 8'h00, "unmapped");
		$display("done ident");
	endtask
	task automatic t_order;
		logic [7:0] cfg [2] = '{8'h02, 8'h40};
		wr(`SCR_A_SCRATCH, 8'ha5);
		rdc(`SCR_A_SCRATCH, 8'ha5, "scratch");
		foreach (cfg[i]) begin
			wr(`SCR_A_CFG_PRI, cfg[i]);
			lsb = 1'b1;
			wr(`SCR_A_SCRATCH, 8'h1c);
			lsb = 1'b0;
			rdc(`SCR_A_SCRATCH, 8'h38, "lsb view");
			lsb = 1'b1;
			wr(`SCR_A_CFG_PRI, 8'h00);
			lsb = 1'b0;
			rdc(`SCR_A_SCRATCH, 8'h1c, "msb view");
		end
		$display("done order");
	endtask
	task automatic t_stream;
		host.xfer(1'b0, `SCR_A_PIN_SEC, 2, 16'h5036, 1'b0, q);
		rdc(`SCR_A_PIN_PRI, 8'h36, "descend");
		wr(`SCR_A_CFG_PRI, 8'h24);
		host.xfer(1'b0, `SCR_A_PIN_GATE, 2, 16'h003f, 1'b0, q);
		host.xfer(1'b1, `SCR_A_PIN_GATE, 2, 16'h0000, 1'b0, q);
		check(q, 16'h003f, "ascend");
		wr(`SCR_A_CFG_PRI, 8'h00);
		$display("done stream");
	endtask
	task automatic t_power;
		wr(`SCR_A_PWR, 8'h02);
		check(power_state, `SCR_PWR_STANDBY, "standby");
		wr(`SCR_A_PWR, 8'h03);
		check(power_state, `SCR_PWR_DOWN, "down");
		check(dp_reset, 1'b1, "down reset");
		wr(`SCR_A_PWR, 8'h00);
		check(power_state, `SCR_PWR_NORMAL, "normal");
		pd_pin = 1'b1;
		wait_n(6);
		check(power_state, `SCR_PWR_DOWN, "pin down");
		wr(`SCR_A_PIN_PRI, 8'h7f);
		check(power_state, `SCR_PWR_STANDBY, "pin stby");
		wr(`SCR_A_PIN_PRI, 8'hbf);
		check(power_state, `SCR_PWR_NORMAL, "pin off");
		wr(`SCR_A_PIN_PRI, 8'h3f);
		wr(`SCR_A_PIN_GATE, 8'h80);
		check(power_state, `SCR_PWR_NORMAL, "gated");
		pd_pin = 1'b0;
		wait_n(4);
		wr(`SCR_A_PIN_GATE, 8'h00);
		$display("done power");
	endtask
	task automatic t_events;
		dp_cnt = 0;
		wr(`SCR_A_CFG_SEC, 8'h02);
		wait_n(10);
		check(16'(dp_cnt), 16'd8, "dp pulse");
		rdc(`SCR_A_CFG_SEC, 8'h00, "dp clear");
		wr(`SCR_A_XFER, 8'h01);
		check(xfer_req, 1'b1, "xfer req");
		rdc(`SCR_A_XFER, 8'h01, "xfer held");
		xfer_done = 1'b1;
		wait_n(1);
		xfer_done = 1'b0;
		wait_n(3);
		check(xfer_req, 1'b0, "xfer end");
		rdc(`SCR_A_XFER, 8'h00, "xfer clear");
		$display("done events");
	endtask
	task automatic t_aux;
		fd_flag = 1'b1;
		wr(`SCR_A_PIN_PRI, 8'h38);
		check(fd_pin, 1'b1, "fd flag");
		wr(`SCR_A_PIN_PRI, 8'h39);
		check(fd_pin, 1'b0, "frame lo");
		frame_clk = 1'b1;
		wait_n(3);
		check(fd_pin, 1'b1, "frame hi");
		wr(`SCR_A_PIN_SEC, 8'h00);
		wr(`SCR_A_PIN_PRI, 8'h37);
		check(nco_sel, 1'b1, "nco sel");
		wr(`SCR_A_PIN_SEC, 8'h10);
		check(nco_sel, 1'b0, "nco other");
		wr(`SCR_A_PIN_PRI, 8'h3f);
		check(fd_pin, 1'b0, "fd off");
		check(nco_sel, 1'b0, "aux two off");
		fd_flag = 1'b0;
		frame_clk = 1'b0;
		$display("done aux");
	endtask
	task automatic t_phase;
		phase = 4'h6;
		rl_cnt = 0;
		for (int i = 0; i < 2; i++) begin
			sysref = 1'b1;
			wait_n(1);
			sysref = 1'b0;
			wait_n(4);
			check(16'(rl_cnt), 16'(i), "realign");
			// capture mode is off for the first sysref pulse only; this write sets it on with the window
			wr(`SCR_A_DIV_ALIGN, 8'h84);
		end
		check(div_offset, 4'h6, "offset");
		rdc(`SCR_A_DIV_STAT, 8'h06, "status");
		rdc(`SCR_A_DIV_ALIGN, 8'h84, "window");
		wr(`SCR_A_DIV_ALIGN, 8'h00);
		$display("done phase");
	endtask
	task automatic t_resets;
		logic [7:0] rv [3] = '{8'h81, 8'h80, 8'h01};
		foreach (rv[i]) begin
			wr(`SCR_A_SCRATCH, 8'h5a);
			wr(`SCR_A_CFG_PRI, 8'h24);
			wr(`SCR_A_CFG_PRI, rv[i]);
			wait_n(20);
			rdc(`SCR_A_SCRATCH, 8'h00, "soft scratch");
			rdc(`SCR_A_CFG_PRI, 8'h00, "soft clear");
		end
		wr(`SCR_A_SCRATCH, 8'h77);
		rstn = 1'b0;
		wait_n(2);
		rstn = 1'b1;
		wait_n(3);
		rdc(`SCR_A_SCRATCH, 8'h00, "hard reset");
		$display("done resets");
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		{rstn, pd_pin, sysref, fd_flag, frame_clk, xfer_done, lsb} = '0;
		phase = 4'h0;
		miscompares = 0;
		n_checks = 0;
		wait_n(10);
		rstn = 1'b1;
		wait_n(3);
		t_defaults();
		t_ident();
		t_order();
		t_stream();
		t_power();
		t_events();
		t_aux();
		t_phase();
		t_resets();
		tally_and_finish();
	end
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		$display("ERROR %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule // scr_bank_test

// File: scr_consts.svh
// constants for the serial configuration register bank
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH
`define SCR_A_CFG_PRI    15'h0000
`define SCR_A_CFG_SEC    15'h0001
`define SCR_A_PWR        15'h0002
`define SCR_A_CLASS      15'h0003
`define SCR_A_PID_LO     15'h0004
`define SCR_A_PID_HI     15'h0005
`define SCR_A_GRADE      15'h0006
`define SCR_A_SCRATCH    15'h000a
`define SCR_A_REV        15'h000b
`define SCR_A_MAKER_LO   15'h000c
`define SCR_A_MAKER_HI   15'h000d
`define SCR_A_XFER       15'h000f
`define SCR_A_PIN_GATE   15'h003f
`define SCR_A_PIN_PRI    15'h0040
`define SCR_A_PIN_SEC    15'h0041
`define SCR_A_DIV_ALIGN  15'h010a
`define SCR_A_DIV_STAT   15'h010b
`define SCR_RST_PIN_PRI  8'h3f
`define SCR_RST_ZERO     8'h00
`define SCR_PWR_NORMAL   2'h0
`define SCR_PWR_STANDBY  2'h2
`define SCR_PWR_DOWN     2'h3
`define SCR_PINF_DOWN    2'h0
`define SCR_PINF_STBY    2'h1
`define SCR_AUX_FD       3'h0
`define SCR_AUX_FRAME    3'h1
`define SCR_AUX_SECOND   3'h6
`define SCR_AUX_OFF      3'h7
`define SCR_SEC_NCO      4'h0
`define SCR_XFER_CYC     4'h4
`define SCR_SOFT_RST_CYC 4'h8
`endif

// File: scr_edge.sv
// rising edge detector on a synchronised level
`timescale 1ns/1ps
module scr_edge
	import scr_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// level and pulse
	input  wire logic level,
	output logic      rise
);
	logic prev;
	logic next_prev;
	always_comb begin
		next_prev = level;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev <= 1'b0;
		end else begin
			prev <= next_prev;
		end
	end
	assign rise = level & ~prev;
endmodule // scr_edge

// File: scr_host.sv
// serial port host model that frames register accesses
`timescale 1ns/1ps
module scr_host (
	// clock
	input  wire logic CLK,
	// serial port pins
	output logic      SCLK,
	output logic      CHIP_SELECT_N,
	output logic      SDIO_IN,
	input  wire logic SDIO_OUT,
	input  wire logic SDIO_OE_N
);
	// ****************
	// frame driver
	// ****************
	initial begin
		SCLK = 1'b0;
		CHIP_SELECT_N = 1'b1;
		SDIO_IN = 1'b0;
	end
	// one bit: data set after the fall, device sampled just before the rise
	task automatic bit_cycle(input logic d, output logic s);
		SDIO_IN = d;
		repeat (6) @(negedge CLK);
		s = (SDIO_OE_N === 1'b0) ? SDIO_OUT : 1'bx;
		SCLK = 1'b1;
		repeat (6) @(negedge CLK);
		SCLK = 1'b0;
	endtask
	// instruction msb first, then n bytes taken from the top of wd
	task automatic xfer(input logic rd, input logic [14:0] a, input int n,
		input logic [15:0] wd, input logic lsb, output logic [15:0] q);
		logic [15:0] ins;
		logic        s;
		int          k;
		int          i;
		ins = {rd, a};
		q = 16'h0000;
		@(negedge CLK);
		CHIP_SELECT_N = 1'b0;
		for (i = 15; i >= 0; i--)
			bit_cycle(ins[i], s);
		for (k = 0; k < n; k++) begin
			for (i = 0; i < 8; i++) begin
				// released line toggles so a stale level never reads true
				bit_cycle(rd ? ~SDIO_IN : wd[lsb ? 8-8*k+i : 15-8*k-i], s);
				if (lsb) q[8-8*k+i] = s;
				else q[15-8*k-i] = s;
			end
		end
		repeat (2) @(negedge CLK);
		CHIP_SELECT_N = 1'b1;
		repeat (4) @(negedge CLK);
	endtask
endmodule // scr_host

// File: scr_pkg.sv
// types shared by the serial configuration register bank
package scr_pkg;
	typedef enum logic [1:0] {SCR_IDLE, SCR_INSTR, SCR_DATA} scr_phase_type;
	typedef struct packed {
		logic [1:0] s;
		logic [1:0] c;
		logic [1:0] d;
	} scr_sync_type;
endpackage

// File: scr_sync.sv
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module scr_sync
	import scr_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// pin and result
	input  wire logic pin,
	output logic      level
);
	logic [1:0] state;
	logic [1:0] next_state;
	always_comb begin
		next_state = {state[0], pin};
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= 2'h0;
		end else begin
			state <= next_state;
		end
	end
	assign level = state[1];
endmodule // scr_sync
